// ==== design/dmrs_pkg.sv ====
package dmrs_pkg;

   // channel count and bus geometry
   localparam int NUM_CH = 10;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // register map, byte addresses
   localparam logic [7:0] CTRL_BASE = 8'h00;
   localparam logic [7:0] SWREQ_BASE = 8'h40;
   localparam logic [7:0] PEND_ADDR = 8'h80;
   localparam logic [1:0] REGION_CTRL = 2'h0;
   localparam logic [1:0] REGION_SWREQ = 2'h1;
   localparam logic [1:0] REGION_STAT = 2'h2;

   // control register fields
   localparam int EN_BIT = 0;
   localparam int SEL_LSB = 2;
   localparam int SEL_W = 2;
   localparam logic SEL_RST = 1'b0;
   localparam logic [1:0] SEL_RST_VAL = 2'h0;
   localparam logic EN_RST_VAL = 1'b0;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

   // selector codes, common to every channel
   localparam logic [1:0] SEL_CODE_0 = 2'h0;
   localparam logic [1:0] SEL_CODE_1 = 2'h1;
   localparam logic [1:0] SEL_CODE_2 = 2'h2;
   localparam logic [1:0] SEL_CODE_3 = 2'h3;

   // bus slave states
   typedef enum logic [1:0]
   {
      BUS_IDLE = 2'b01,
      BUS_ACK = 2'b10
   } dmrs_bus_e;

endpackage

// ==== design/dmrs_chan_req.sv ====
`timescale 1ns/100ps
`default_nettype none

module dmrs_chan_req
(
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic enable_i,
   input wire logic [1:0] sel_i,
   input wire logic [3:0] src_i,
   input wire logic ack_i,
   output logic pending_o
);

   logic pend_ff;
   logic nxt_pend;
   logic hit;

   always_comb
   begin
      hit = src_i[sel_i];
      nxt_pend = pend_ff;
      if (!enable_i)
      begin
         // nothing is taken before the channel is enabled
         nxt_pend = 1'b0;
      end
      else if (hit)
      begin
         // a new event wins over a service in the same cycle
         nxt_pend = 1'b1;
      end
      else if (ack_i)
      begin
         nxt_pend = 1'b0;
      end
   end

   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
         pend_ff <= 1'b0;
      else
         pend_ff <= nxt_pend;
   end

   assign pending_o = pend_ff;

   sequence ev_taken_s;
      enable_i && src_i[sel_i];
   endsequence

   sequence held_s;
      pend_ff && enable_i && !ack_i;
   endsequence

   ev_sets_pend_a: assert property (
      @(posedge clock_i) disable iff (reset_i)
      ev_taken_s |=> pending_o)
      else $error("selected event did not set pending");

   pend_holds_a: assert property (
      @(posedge clock_i) disable iff (reset_i)
      held_s |=> pending_o)
      else $error("pending dropped before service");

   disabled_idle_a: assert property (
      @(posedge clock_i) disable iff (reset_i)
      !enable_i |=> !pending_o)
      else $error("pending while channel disabled");

endmodule

`default_nettype wire

// ==== design/dmrs_top.sv ====
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none

module dmrs_top
#(
   parameter int NUM_CH = dmrs_pkg::NUM_CH
)
(
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic converter_unit_0_done_i,
   input wire logic timer_ch8_underflow_i,
   input wire logic [2:0] timer_in_bus_i,
   input wire logic [1:0] timer_out_bus_i,
   input wire logic [20:0] timer_input_i,
   input wire logic [3:0] sio_tx_empty_i,
   input wire logic [3:0] sio_rx_done_i,
   input wire logic [9:0] xfer_one_done_i,
   input wire logic [9:0] xfer_count_underflow_i,
   input wire logic [9:0] service_ack_i,
   output logic [9:0] dma_request_o,
   output logic [9:0] transfer_enable_o
);

   if (NUM_CH != 10)
   begin : g_bad_ch
      $error("source table is fixed at ten channels");
   end

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (reset_i);

   dmrs_pkg::dmrs_bus_e state_ff;
   dmrs_pkg::dmrs_bus_e nxt_state;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic [1:0] sel_ff [NUM_CH];
   logic [1:0] nxt_sel [NUM_CH];
   logic [NUM_CH-1:0] en_ff;
   logic [NUM_CH-1:0] nxt_en;
   logic [NUM_CH-1:0] sw_pulse;
   logic [NUM_CH-1:0] pending;
   logic [3:0] src [NUM_CH];
   logic access;
   logic take;
   logic [1:0] region;
   logic [3:0] index;
   logic index_ok;

   // bus slave: one wait cycle, answer on the second edge
   assign access = avs_read_i || avs_write_i;
   assign take = access && (state_ff == dmrs_pkg::BUS_ACK);
   assign avs_waitrequest_o = access && (state_ff == dmrs_pkg::BUS_IDLE);
   assign region = avs_address_i[7:6];
   assign index = avs_address_i[5:2];
   assign index_ok = (index < 4'(NUM_CH));

   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         dmrs_pkg::BUS_IDLE:
         begin
            if (access)
               nxt_state = dmrs_pkg::BUS_ACK;
         end
         dmrs_pkg::BUS_ACK:
         begin
            nxt_state = dmrs_pkg::BUS_IDLE;
         end
         default:
         begin
            nxt_state = dmrs_pkg::BUS_IDLE;
         end
      endcase
   end

   always_comb
   begin
      nxt_rdata = rdata_ff;
      if (avs_read_i && state_ff == dmrs_pkg::BUS_IDLE)
      begin
         nxt_rdata = dmrs_pkg::UNMAPPED_DATA;
         if (region == dmrs_pkg::REGION_CTRL && index_ok)
         begin
            nxt_rdata[dmrs_pkg::SEL_LSB +: dmrs_pkg::SEL_W] = sel_ff[index];
            nxt_rdata[dmrs_pkg::EN_BIT] = en_ff[index];
         end
         else if (avs_address_i == dmrs_pkg::PEND_ADDR)
         begin
            nxt_rdata[NUM_CH-1:0] = pending;
         end
      end
   end

   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         state_ff <= dmrs_pkg::BUS_IDLE;
         rdata_ff <= dmrs_pkg::UNMAPPED_DATA;
      end
      else
      begin
         state_ff <= nxt_state;
         rdata_ff <= nxt_rdata;
      end
   end

   assign avs_readdata_o = rdata_ff;

   // control registers and software request strobes
   always_comb
   begin
      for (int i = 0; i < NUM_CH; i++)
      begin
         nxt_sel[i] = sel_ff[i];
         nxt_en[i] = en_ff[i];
         sw_pulse[i] = 1'b0;
         if (take && avs_write_i && index == 4'(i))
         begin
            if (region == dmrs_pkg::REGION_CTRL && avs_byteenable_i[0])
            begin
               nxt_sel[i] = avs_writedata_i[dmrs_pkg::SEL_LSB +:
                                            dmrs_pkg::SEL_W];
               nxt_en[i] = avs_writedata_i[dmrs_pkg::EN_BIT];
            end
            // any data value starts the channel
            if (region == dmrs_pkg::REGION_SWREQ)
               sw_pulse[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         for (int i = 0; i < NUM_CH; i++)
            sel_ff[i] <= dmrs_pkg::SEL_RST_VAL;
         en_ff <= {NUM_CH{dmrs_pkg::EN_RST_VAL}};
      end
      else
      begin
         for (int i = 0; i < NUM_CH; i++)
            sel_ff[i] <= nxt_sel[i];
         en_ff <= nxt_en;
      end
   end

   assign transfer_enable_o = en_ff;

   // source table, bit n answers selector code n
   always_comb
   begin
      src[0] = {timer_in_bus_i[2], timer_ch8_underflow_i,
                converter_unit_0_done_i,
                sw_pulse[0] || xfer_one_done_i[2]};
      src[1] = {xfer_one_done_i[0], timer_input_i[13], timer_out_bus_i[0],
                sw_pulse[1]};
      src[2] = {xfer_one_done_i[1], timer_input_i[18], timer_out_bus_i[1],
                sw_pulse[2]};
      src[3] = {timer_input_i[0], sio_rx_done_i[1], sio_tx_empty_i[0],
                sw_pulse[3]};
      src[4] = {timer_input_i[19], sio_rx_done_i[0], xfer_one_done_i[3],
                sw_pulse[4]};
      // all-done cascade taken from the count underflow
      src[5] = {timer_input_i[20], sio_rx_done_i[2],
                xfer_count_underflow_i[0],
                sw_pulse[5] || xfer_one_done_i[7]};
      src[6] = {xfer_one_done_i[5], timer_input_i[1], sio_tx_empty_i[1],
                sw_pulse[6]};
      src[7] = {xfer_one_done_i[6], timer_input_i[2], sio_tx_empty_i[2],
                sw_pulse[7]};
      src[8] = {timer_input_i[7], sio_rx_done_i[3], timer_in_bus_i[0],
                sw_pulse[8]};
      src[9] = {xfer_one_done_i[8], timer_input_i[8], sio_tx_empty_i[3],
                sw_pulse[9]};
   end

   for (genvar g = 0; g < NUM_CH; g++)
   begin : g_ch
      dmrs_chan_req u_req
      (
         .clock_i (clock_i),
         .reset_i (reset_i),
         .enable_i (en_ff[g]),
         .sel_i (sel_ff[g]),
         .src_i (src[g]),
         .ack_i (service_ack_i[g]),
         .pending_o (pending[g])
      );
   end

   // request shown only while enabled
   assign dma_request_o = pending & en_ff;

   sequence sw_write_s(int ch);
      take && avs_write_i && region == dmrs_pkg::REGION_SWREQ &&
         index == 4'(ch);
   endsequence

   bus_wait_a: assert property (
      access && state_ff == dmrs_pkg::BUS_IDLE |-> avs_waitrequest_o
      ##1 !avs_waitrequest_o)
      else $error("slave did not answer on the second edge");

   ctrl_write_a: assert property (
      take && avs_write_i && region == dmrs_pkg::REGION_CTRL &&
      index == 4'h3 && avs_byteenable_i[0]
      |=> sel_ff[3] == $past(avs_writedata_i[3:2]))
      else $error("selector field not written");

   sw_start_a: assert property (
      sw_write_s(4) ##0 (sel_ff[4] == dmrs_pkg::SEL_CODE_0 && en_ff[4])
      |=> dma_request_o[4])
      else $error("software write raised no request");

   conv_src_a: assert property (
      en_ff[0] && sel_ff[0] == dmrs_pkg::SEL_CODE_1 &&
      converter_unit_0_done_i |=> dma_request_o[0])
      else $error("converter event lost on channel 0");

   cascade_one_a: assert property (
      en_ff[1] && sel_ff[1] == dmrs_pkg::SEL_CODE_3 && xfer_one_done_i[0]
      |=> dma_request_o[1])
      else $error("one-done cascade lost on channel 1");

   cascade_all_a: assert property (
      en_ff[5] && sel_ff[5] == dmrs_pkg::SEL_CODE_1 &&
      xfer_count_underflow_i[0] |=> dma_request_o[5])
      else $error("all-done cascade lost on channel 5");

   pin_src_a: assert property (
      en_ff[9] && sel_ff[9] == dmrs_pkg::SEL_CODE_2 && timer_input_i[8]
      |=> dma_request_o[9])
      else $error("timer input 8 lost on channel 9");

   no_req_off_a: assert property (
      !en_ff[2] |=> !pending[2])
      else $error("pending kept while channel 2 disabled");

   wrong_sel_a: assert property (
      !en_ff[3] ##1 (en_ff[3] && sel_ff[3] == dmrs_pkg::SEL_CODE_1 &&
      !sio_tx_empty_i[0] && !sw_pulse[3]) |=> !dma_request_o[3])
      else $error("channel 3 raised an unselected request");

   cascade_sw_a: assert property (
      en_ff[0] && sel_ff[0] == dmrs_pkg::SEL_CODE_0 && xfer_one_done_i[2]
      |=> dma_request_o[0])
      else $error("channel 2 one-done cascade lost on channel 0");

   pin13_src_a: assert property (
      en_ff[1] && sel_ff[1] == dmrs_pkg::SEL_CODE_2 && timer_input_i[13]
      |=> dma_request_o[1])
      else $error("timer input 13 lost on channel 1");

   obus_src_a: assert property (
      en_ff[2] && sel_ff[2] == dmrs_pkg::SEL_CODE_1 && timer_out_bus_i[1]
      |=> dma_request_o[2])
      else $error("timer output bus 1 lost on channel 2");

   rx_src_a: assert property (
      en_ff[4] && sel_ff[4] == dmrs_pkg::SEL_CODE_2 && sio_rx_done_i[0]
      |=> dma_request_o[4])
      else $error("serial 0 receive lost on channel 4");

   tx_src_a: assert property (
      en_ff[6] && sel_ff[6] == dmrs_pkg::SEL_CODE_1 && sio_tx_empty_i[1]
      |=> dma_request_o[6])
      else $error("serial 1 transmit empty lost on channel 6");

   chain_src_a: assert property (
      en_ff[7] && sel_ff[7] == dmrs_pkg::SEL_CODE_3 && xfer_one_done_i[6]
      |=> dma_request_o[7])
      else $error("channel 6 one-done cascade lost on channel 7");

   ibus_src_a: assert property (
      en_ff[8] && sel_ff[8] == dmrs_pkg::SEL_CODE_1 && timer_in_bus_i[0]
      |=> dma_request_o[8])
      else $error("timer input bus 0 lost on channel 8");

   ev_wins_a: assert property (
      en_ff[3] && sel_ff[3] == dmrs_pkg::SEL_CODE_1 && sio_tx_empty_i[0] &&
      service_ack_i[3] |=> dma_request_o[3])
      else $error("service cleared a fresh request on channel 3");

endmodule

`default_nettype wire

// ==== test/dmrs_far_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module dmrs_far_model
(
   input wire logic go_i,
   input wire logic [6:0] pick_i,
   output logic ad_o,
   output logic udf_o,
   output logic [2:0] ibus_o,
   output logic [1:0] obus_o,
   output logic [20:0] tin_o,
   output logic [3:0] stx_o,
   output logic [3:0] srx_o,
   output logic [9:0] one_o,
   output logic [9:0] uf_o
);
   // one-cycle event on the source named by {channel, code}
   always_comb
   begin
      ad_o = 1'b0;
      udf_o = 1'b0;
      ibus_o = 3'h0;
      obus_o = 2'h0;
      tin_o = 21'h0;
      stx_o = 4'h0;
      srx_o = 4'h0;
      one_o = 10'h0;
      uf_o = 10'h0;
      if (go_i)
      begin
         case (pick_i)
            7'h01: ad_o = 1'b1;
            7'h02: udf_o = 1'b1;
            7'h03: ibus_o[2] = 1'b1;
            7'h04: one_o[2] = 1'b1;
            7'h09: obus_o[0] = 1'b1;
            7'h0a: tin_o[13] = 1'b1;
            7'h0b: one_o[0] = 1'b1;
            7'h11: obus_o[1] = 1'b1;
            7'h12: tin_o[18] = 1'b1;
            7'h13: one_o[1] = 1'b1;
            7'h19: stx_o[0] = 1'b1;
            7'h1a: srx_o[1] = 1'b1;
            7'h1b: tin_o[0] = 1'b1;
            7'h21: one_o[3] = 1'b1;
            7'h22: srx_o[0] = 1'b1;
            7'h23: tin_o[19] = 1'b1;
            7'h29: uf_o[0] = 1'b1;
            7'h2a: srx_o[2] = 1'b1;
            7'h2b: tin_o[20] = 1'b1;
            7'h2c: one_o[7] = 1'b1;
            7'h31: stx_o[1] = 1'b1;
            7'h32: tin_o[1] = 1'b1;
            7'h33: one_o[5] = 1'b1;
            7'h39: stx_o[2] = 1'b1;
            7'h3a: tin_o[2] = 1'b1;
            7'h3b: one_o[6] = 1'b1;
            7'h41: ibus_o[0] = 1'b1;
            7'h42: srx_o[3] = 1'b1;
            7'h43: tin_o[7] = 1'b1;
            7'h49: stx_o[3] = 1'b1;
            7'h4a: tin_o[8] = 1'b1;
            7'h4b: one_o[8] = 1'b1;
            default: ;
         endcase
      end
   end
endmodule

`default_nettype wire

// ==== test/dmrs_top_tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module dmrs_top_tb;
   logic clock_i = 1'b0;
   logic reset_i = 1'b1;
   logic [7:0] avs_address_i = 8'h00;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'hf;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic [9:0] service_ack_i = 10'h0;
   logic [9:0] dma_request_o;
   logic [9:0] transfer_enable_o;
   logic go = 1'b0;
   logic [6:0] pick = 7'h00;
   logic ad, udf;
   logic [2:0] ibus;
   logic [1:0] obus;
   logic [20:0] tin;
   logic [3:0] stx, srx;
   logic [9:0] one, uf;
   logic [31:0] rd;
   integer seed = 32'hc84d;
   int bad_count = 0;
   int cmp_count = 0;

   always #12.5 clock_i = ~clock_i;

   dmrs_top DUT (.clock_i, .reset_i, .avs_address_i, .avs_read_i,
      .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
      .avs_waitrequest_o, .converter_unit_0_done_i(ad),
      .timer_ch8_underflow_i(udf), .timer_in_bus_i(ibus),
      .timer_out_bus_i(obus), .timer_input_i(tin), .sio_tx_empty_i(stx),
      .sio_rx_done_i(srx), .xfer_one_done_i(one),
      .xfer_count_underflow_i(uf), .service_ack_i, .dma_request_o,
      .transfer_enable_o);

   dmrs_far_model far (.go_i(go), .pick_i(pick), .ad_o(ad), .udf_o(udf),
      .ibus_o(ibus), .obus_o(obus), .tin_o(tin), .stx_o(stx),
      .srx_o(srx), .one_o(one), .uf_o(uf));

   function automatic logic [31:0] ctl(input logic [1:0] s, input logic e);
      return {28'h0, s, 1'b0, e};
   endfunction

   task automatic summarize();
      $display("mismatches %0d, compares %0d", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clock_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      n = 0;
      // waitrequest and read data are sampled at the rising edge
      do
      begin
         @(posedge clock_i);
         n++;
      end
      while (avs_waitrequest_o !== 1'b0 && n < 20);
      if (avs_waitrequest_o !== 1'b0)
      begin
         bad_count++;
         summarize();
      end
      else
      begin
         q = avs_readdata_o;
         avs_write_i <= 1'b0;
         avs_read_i <= 1'b0;
      end
   endtask

   // raise the selected source for one cycle, or write the start register
   task automatic trig(input int ch, input int k);
      if (k == 0)
         bus(1'b1, dmrs_pkg::SWREQ_BASE + 8'(4 * ch), $random(seed), rd);
      else
      begin
         go <= 1'b1;
         pick <= 7'(ch * 8 + k);
         @(posedge clock_i);
         go <= 1'b0;
      end
      repeat (3) @(posedge clock_i);
      @(negedge clock_i);
   endtask

   initial
   begin
      logic [9:0] m;
      logic [7:0] a;
      repeat (6) @(posedge clock_i);
      reset_i <= 1'b0;
      @(posedge clock_i);
      chk(32'(dma_request_o | transfer_enable_o), 32'h0);
      bus(1'b0, 8'h24, 32'h0, rd);
      chk(rd, ctl(2'h0, 1'b0));
      bus(1'b0, 8'hfc, 32'h0, rd);
      chk(rd, dmrs_pkg::UNMAPPED_DATA);
      avs_byteenable_i <= 4'he;
      bus(1'b1, 8'h00, 32'h0d, rd);
      avs_byteenable_i <= 4'hf;
      bus(1'b0, 8'h00, 32'h0, rd);
      chk(rd, 32'h0);
      for (int ch = 0; ch < 10; ch++)
         for (int k = 0; k < 5; k++)
         begin
            if (k == 4 && ch != 0 && ch != 5)
               continue;
            m = 10'h001 << ch;
            a = dmrs_pkg::CTRL_BASE + 8'(4 * ch);
            bus(1'b1, a, ($random(seed) & 32'hffff_fff2) | ctl(2'(k), 1'b1), rd);
            bus(1'b0, a, 32'h0, rd);
            chk(rd, ctl(2'(k), 1'b1));
            chk(32'(transfer_enable_o), 32'(m));
            trig(ch, k);
            chk(32'(dma_request_o), 32'(m));
            chk(32'(dma_request_o), 32'(m));
            bus(1'b0, dmrs_pkg::PEND_ADDR, 32'h0, rd);
            chk(rd, 32'(m));
            service_ack_i <= m;
            @(posedge clock_i);
            service_ack_i <= 10'h0;
            @(negedge clock_i);
            chk(32'(dma_request_o), 32'h0);
            @(posedge clock_i);
            bus(1'b1, a, ctl(2'(k), 1'b0), rd);
            trig(ch, k);
            chk(32'(dma_request_o), 32'h0);
            @(posedge clock_i);
         end
      // event and service in one cycle: the event must win
      bus(1'b1, dmrs_pkg::CTRL_BASE + 8'h0c, ctl(2'h1, 1'b1), rd);
      go <= 1'b1;
      pick <= 7'h19;
      service_ack_i <= 10'h008;
      @(posedge clock_i);
      go <= 1'b0;
      service_ack_i <= 10'h0;
      @(negedge clock_i);
      chk(32'(dma_request_o), 32'h008);
      // reset in mid-run clears requests, enables and selectors
      @(posedge clock_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      reset_i <= 1'b0;
      @(negedge clock_i);
      chk(32'(dma_request_o | transfer_enable_o), 32'h0);
      bus(1'b0, dmrs_pkg::CTRL_BASE + 8'h0c, 32'h0, rd);
      chk(rd, ctl(2'h0, 1'b0));
      summarize();
   end
endmodule

`default_nettype wire
